//--- sadc_pkg.sv
// Purpose: shared constants and types for the successive-approximation converter control
// Assumes: 8-bit register port, 25 MHz system clock
// Notes:   offsets other than the control register are local choices
package sadc_pkg;
  localparam logic [7:0] SADC_CTRL_ADDR   = 8'h1f;
  localparam logic [7:0] SADC_RESULT_ADDR = 8'h1e;
  localparam logic [7:0] SADC_PCFG_ADDR   = 8'h9f;
  localparam logic [7:0] SADC_IRQ_STAT    = 8'h20;
  localparam logic [7:0] SADC_IRQ_EN      = 8'h21;
  localparam logic [7:0] SADC_IRQ_CLR     = 8'h22;
  localparam logic [7:0] SADC_SLEEP_ADDR  = 8'h23;
  // control register field positions
  localparam int SADC_CS_HI   = 7;
  localparam int SADC_CS_LO   = 6;
  localparam int SADC_CH_HI   = 5;
  localparam int SADC_CH_LO   = 3;
  localparam int SADC_GO_BIT  = 2;
  localparam int SADC_ON_BIT  = 0;
  localparam logic [7:0] SADC_CTRL_MASK  = 8'hfd;
  localparam logic [7:0] SADC_CTRL_RESET = 8'h00;
  localparam logic [7:0] SADC_PCFG_MASK  = 8'h07;
  // clock select codes
  localparam logic [1:0] SADC_CS_DIV2  = 2'h0;
  localparam logic [1:0] SADC_CS_DIV8  = 2'h1;
  localparam logic [1:0] SADC_CS_DIV32 = 2'h2;
  localparam logic [1:0] SADC_CS_RC    = 2'h3;
  // timing
  localparam int SADC_CLK_MHZ     = 25;
  localparam int SADC_RC_TAD_NS   = 4000;
  localparam int SADC_RC_TAD_CYC  = SADC_RC_TAD_NS * SADC_CLK_MHZ / 1000;
  localparam int SADC_TAD_PER_CNV = 9;
  localparam int SADC_BITS        = 8;
  typedef struct packed {
    logic [1:0] clk_sel;
    logic [2:0] chan;
    logic       go;
    logic       pwr_on;
  } sadc_ctrl_t;
  typedef struct packed {
    logic       compare_req;
    logic [7:0] trial_code;
  } sadc_dac_t;
endpackage : sadc_pkg

//--- sadc_tad_gen.sv
// Purpose: conversion clock enable generator, one pulse per bit period
// Assumes: system clock is the device oscillator
// Notes:   rc source is modelled by a counter of the rc period
`timescale 1ns/10ps
module sadc_tad_gen #(
  parameter int RC_CYCLES = sadc_pkg::SADC_RC_TAD_CYC
) (
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  input  wire logic       run_in,
  input  wire logic [1:0] clk_sel_in,
  output logic            tad_out
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [15:0] limit;
  logic        tad_ff;
  logic        nxt_tad;
  //////////////////////////////////////////////////////////////////////////
  // divider terminal count per select code
  always_comb begin
    unique case (clk_sel_in)
      sadc_pkg::SADC_CS_DIV2:  limit = 16'h0001;
      sadc_pkg::SADC_CS_DIV8:  limit = 16'h0007;
      sadc_pkg::SADC_CS_DIV32: limit = 16'h001f;
      sadc_pkg::SADC_CS_RC:    limit = 16'(RC_CYCLES - 1);
    endcase
    nxt_cnt = 16'h0000;
    nxt_tad = 1'b0;
    if (run_in) begin
      if (cnt_ff >= limit) begin
        nxt_tad = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_ff <= 16'h0000;
      tad_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tad_ff <= nxt_tad;
    end
  end
  assign tad_out = tad_ff;
endmodule // sadc_tad_gen

//--- sadc_sar.sv
// Purpose: successive-approximation register, one bit per period
// Assumes: comparator answer valid while compare request is high
// Notes:   nine periods: one sample, eight bit decisions
`timescale 1ns/10ps
module sadc_sar #(
  parameter int BITS = sadc_pkg::SADC_BITS
) (
  input  wire logic            clk_sys_in,
  input  wire logic            reset_n_in,
  input  wire logic            start_in,
  input  wire logic            abort_in,
  input  wire logic            tad_in,
  input  wire logic            cmp_hi_in,
  output logic [BITS-1:0]      code_out,
  output logic [BITS-1:0]      trial_out,
  output logic                 busy_out,
  output logic                 done_out
);
  logic [BITS-1:0] code_ff;
  logic [BITS-1:0] nxt_code;
  logic [3:0]      step_ff;
  logic [3:0]      nxt_step;
  logic            busy_ff;
  logic            nxt_busy;
  logic            done_ff;
  logic            nxt_done;
  logic [BITS-1:0] bit_mask;
  //////////////////////////////////////////////////////////////////////////
  // step 0 samples, steps 1..BITS resolve msb first
  always_comb begin
    bit_mask = '0;
    if (step_ff != 4'h0 && step_ff <= 4'(BITS)) begin
      bit_mask = BITS'(1) << (4'(BITS) - step_ff);
    end
    trial_out = code_ff | bit_mask;
    nxt_code  = code_ff;
    nxt_step  = step_ff;
    nxt_busy  = busy_ff;
    nxt_done  = 1'b0;
    if (abort_in) begin
      nxt_busy = 1'b0;
    end else if (start_in && !busy_ff) begin
      nxt_busy = 1'b1;
      nxt_step = 4'h0;
      nxt_code = '0;
    end else if (busy_ff && tad_in) begin
      if (step_ff != 4'h0) begin
        nxt_code = cmp_hi_in ? trial_out : code_ff;
      end
      if (step_ff == 4'(BITS)) begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end else begin
        nxt_step = step_ff + 4'h1;
      end
    end
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      code_ff <= '0;
      step_ff <= 4'h0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      code_ff <= nxt_code;
      step_ff <= nxt_step;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end
  assign code_out = code_ff;
  assign busy_out = busy_ff;
  assign done_out = done_ff;
endmodule // sadc_sar

//--- sadc_ctrl.sv
// Purpose: register file and sequencing for the 8-bit converter
// Assumes: comparator from the analog core arrives asynchronously
// Notes:   one level interrupt output
//
// Summary of operation
// - result is an unsigned 8-bit code built by successive approximation
// - five inputs on small variant, eight on large; codes above four unused
// - reference is supply or external reference pin, chosen by software
// - conversion runs during sleep only with the internal rc clock
// - bits 7-6 pick clock; 10 gives divide by 32, 11 internal rc
// - control register at 1f, all implemented bits reset to zero
// - each capable pin is analog input or digital; reference pin may be reference
// - setting start converts; then result stored, start cleared, done flag set
// - clearing start mid-conversion aborts; result kept, no done flag
// - a conversion lasts nine bit periods
// - code 00 gives divide by 2, code 01 divide by 8
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
module sadc_ctrl #(
  parameter int  CHANNELS  = 8,
  parameter int  RC_CYCLES = sadc_pkg::SADC_RC_TAD_CYC
) (
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic       sleep_in,
  input  wire logic       cmp_hi_in,
  output logic [7:0]      rdata_out,
  output logic [2:0]      chan_sel_out,
  output logic            chan_valid_out,
  output logic            sample_out,
  output logic [7:0]      dac_code_out,
  output logic            ext_ref_out,
  output logic [2:0]      port_cfg_out,
  output logic            powered_out,
  output logic            irq_out
);
  sadc_pkg::sadc_ctrl_t ctrl_ff, nxt_ctrl;
  logic [7:0] result_ff, nxt_result;
  logic [2:0] pcfg_ff, nxt_pcfg;
  logic       stat_ff, nxt_stat;
  logic       ien_ff, nxt_ien;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [2:0] chan_ff;
  logic       cvalid_ff, sample_ff, ext_ref_ff, pwr_ff, irq_ff;
  logic [7:0] dac_ff;
  logic [2:0] cmp_sync_ff;
  logic       cmp_stable_ff, nxt_cmp_stable;
  logic       sar_start, sar_abort, sar_busy, sar_done, tad, run_ok, rc_sel;
  logic [7:0] sar_code, sar_trial;
  //////////////////////////////////////////////////////////////////////////
  // comparator synchroniser: takes the third stage once second and third stage agree
  always_comb begin
    nxt_cmp_stable = cmp_stable_ff;
    if (cmp_sync_ff[1] == cmp_sync_ff[2]) begin
      nxt_cmp_stable = cmp_sync_ff[2];
    end
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmp_sync_ff   <= 3'h0;
      cmp_stable_ff <= 1'b0;
    end else begin
      cmp_sync_ff   <= {cmp_sync_ff[1:0], cmp_hi_in};
      cmp_stable_ff <= nxt_cmp_stable;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // run gating: sleep stops any non-rc conversion
  always_comb begin
    rc_sel    = (ctrl_ff.clk_sel == sadc_pkg::SADC_CS_RC);
    run_ok    = ctrl_ff.pwr_on && (!sleep_in || rc_sel);
    sar_start = ctrl_ff.go && run_ok && !sar_done;
    sar_abort = sar_busy && (!ctrl_ff.go || !run_ok);
  end
  sadc_tad_gen #(
    .RC_CYCLES  (RC_CYCLES)
  ) u_tad (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .run_in     (sar_busy && !sar_abort),
    .clk_sel_in (ctrl_ff.clk_sel),
    .tad_out    (tad)
  );
  // nine periods: sample then eight decisions
  sadc_sar #(
    .BITS       (sadc_pkg::SADC_BITS)
  ) u_sar (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .start_in   (sar_start),
    .abort_in   (sar_abort),
    .tad_in     (tad),
    .cmp_hi_in  (cmp_stable_ff),
    .code_out   (sar_code),
    .trial_out  (sar_trial),
    .busy_out   (sar_busy),
    .done_out   (sar_done)
  );
  //////////////////////////////////////////////////////////////////////////
  // register writes, completion and interrupt status
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_result = result_ff;
    nxt_pcfg   = pcfg_ff;
    nxt_stat   = stat_ff;
    nxt_ien    = ien_ff;
    if (wr_in) begin
      unique case (addr_in)
        sadc_pkg::SADC_CTRL_ADDR: begin
          nxt_ctrl.clk_sel = wdata_in[sadc_pkg::SADC_CS_HI:sadc_pkg::SADC_CS_LO];
          nxt_ctrl.chan    = wdata_in[sadc_pkg::SADC_CH_HI:sadc_pkg::SADC_CH_LO];
          nxt_ctrl.go      = wdata_in[sadc_pkg::SADC_GO_BIT];
          nxt_ctrl.pwr_on  = wdata_in[sadc_pkg::SADC_ON_BIT];
        end
        sadc_pkg::SADC_PCFG_ADDR: nxt_pcfg = wdata_in[2:0];
        sadc_pkg::SADC_IRQ_EN:    nxt_ien  = wdata_in[0];
        sadc_pkg::SADC_IRQ_CLR:   nxt_stat = stat_ff & ~wdata_in[0];
        default: ;
      endcase
    end
    // start request with no power or in sleep without rc drops at once
    if (nxt_ctrl.go && !sar_busy && !run_ok && !wr_in) begin
      nxt_ctrl.go = 1'b0;
    end
    if (sar_done && ctrl_ff.go) begin
      nxt_result  = sar_code;
      nxt_ctrl.go = 1'b0;
      nxt_stat    = 1'b1;                                                  // set beats clear
    end
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_ff   <= sadc_pkg::sadc_ctrl_t'(7'h00);
      result_ff <= 8'h00;
      pcfg_ff   <= 3'h0;
      stat_ff   <= 1'b0;
      ien_ff    <= 1'b0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      result_ff <= nxt_result;
      pcfg_ff   <= nxt_pcfg;
      stat_ff   <= nxt_stat;
      ien_ff    <= nxt_ien;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // read mux, data one cycle after the strobe
  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        sadc_pkg::SADC_CTRL_ADDR:   nxt_rdata = {ctrl_ff.clk_sel, ctrl_ff.chan,
                                                 ctrl_ff.go, 1'b0, ctrl_ff.pwr_on};
        sadc_pkg::SADC_RESULT_ADDR: nxt_rdata = result_ff;
        sadc_pkg::SADC_PCFG_ADDR:   nxt_rdata = {5'h00, pcfg_ff};
        sadc_pkg::SADC_IRQ_STAT:    nxt_rdata = {7'h00, stat_ff};
        sadc_pkg::SADC_IRQ_EN:      nxt_rdata = {7'h00, ien_ff};
        sadc_pkg::SADC_SLEEP_ADDR:  nxt_rdata = {6'h00, sar_busy, sleep_in};
        default:                    nxt_rdata = 8'h00;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // registered analog-side and interrupt outputs
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_ff   <= 8'h00;
      chan_ff    <= 3'h0;
      cvalid_ff  <= 1'b0;
      sample_ff  <= 1'b0;
      dac_ff     <= 8'h00;
      ext_ref_ff <= 1'b0;
      pwr_ff     <= 1'b0;
      irq_ff     <= 1'b0;
    end else begin
      rdata_ff   <= nxt_rdata;
      chan_ff    <= ctrl_ff.chan;
      cvalid_ff  <= (32'(ctrl_ff.chan) < CHANNELS);
      sample_ff  <= !sar_busy && run_ok;
      dac_ff     <= sar_trial;
      ext_ref_ff <= pcfg_ff[0] && !pcfg_ff[2] | (pcfg_ff == 3'h5);
      pwr_ff     <= run_ok;
      irq_ff     <= stat_ff && ien_ff;
    end
  end
  assign rdata_out      = rdata_ff;
  assign chan_sel_out   = chan_ff;
  assign chan_valid_out = cvalid_ff;
  assign sample_out     = sample_ff;
  assign dac_code_out   = dac_ff;
  assign ext_ref_out    = ext_ref_ff;
  assign port_cfg_out   = pcfg_ff;
  assign powered_out    = pwr_ff;
  assign irq_out        = irq_ff;
endmodule // sadc_ctrl

//--- sadc_ctrl_checker.sv
// Purpose: port properties of the converter control
// Assumes: one clock, async active-low reset
// Notes:   attached by the bind below the module
`timescale 1ns/10ps
module sadc_ctrl_checker #(
  parameter int CHANNELS = 8
) (
  input wire logic       clk_sys_in,
  input wire logic       reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [2:0] chan_sel_out,
  input wire logic       chan_valid_out,
  input wire logic       sample_out,
  input wire logic       ext_ref_out,
  input wire logic [2:0] port_cfg_out,
  input wire logic       powered_out,
  input wire logic       irq_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);
  // control write followed by a quiet cycle
  sequence s_ctl_wr;
    wr_in && addr_in == sadc_pkg::SADC_CTRL_ADDR ##1 !wr_in;
  endsequence
  sequence s_off_wr;
    wr_in && addr_in == sadc_pkg::SADC_CTRL_ADDR && !wdata_in[0] ##1 !wr_in;
  endsequence
  property p_rd_idle; !rd_in |=> rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_bit1; rd_in && addr_in == sadc_pkg::SADC_CTRL_ADDR |=> !rdata_out[1]; endproperty
  a_bit1: assert property (p_bit1) else $error("reserved control bit set");
  property p_unmap; rd_in && addr_in == 8'h55 |=> rdata_out == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_chan; s_ctl_wr |=> chan_sel_out == $past(wdata_in[5:3], 2); endproperty
  a_chan: assert property (p_chan) else $error("channel select wrong");
  property p_valid;
    $stable(chan_sel_out) && $past(reset_n_in, 2) |-> chan_valid_out == (chan_sel_out < CHANNELS);
  endproperty
  a_valid: assert property (p_valid) else $error("channel valid wrong");
  property p_ref;
    $stable(port_cfg_out) && $past(reset_n_in, 2)
      |-> ext_ref_out == (port_cfg_out inside {3'h1, 3'h3, 3'h5});
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");
  property p_off; s_off_wr |=> !powered_out; endproperty
  a_off: assert property (p_off) else $error("converter stays powered");
  property p_sample; !powered_out && !$past(powered_out) |-> !sample_out; endproperty
  a_sample: assert property (p_sample) else $error("sampling while off");
  property p_irq_off;
    wr_in && addr_in == sadc_pkg::SADC_IRQ_EN && !wdata_in[0] |-> ##2 !irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked interrupt high");
endmodule // sadc_ctrl_checker
////////////////////////////////////////
bind sadc_ctrl sadc_ctrl_checker #(.CHANNELS(CHANNELS)) chk_u (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .chan_sel_out(chan_sel_out),
  .chan_valid_out(chan_valid_out), .sample_out(sample_out), .ext_ref_out(ext_ref_out),
  .port_cfg_out(port_cfg_out), .powered_out(powered_out), .irq_out(irq_out));

//--- sadc_analog_model.sv
// Purpose: analog mux, sample-and-hold and comparator stand-in
// Assumes: eight fixed input levels from the bench
// Notes:   held level is unknown until the first sample
`timescale 1ns/10ps
module sadc_analog_model (
  input  wire logic        clk_sys_in,
  input  wire logic [63:0] levels_in,
  input  wire logic [2:0]  chan_sel_in,
  input  wire logic        sample_in,
  input  wire logic [7:0]  dac_code_in,
  output logic             cmp_hi_out
);
  logic [7:0] held_ff;
  // track the routed input while sampling, freeze during conversion
  always_ff @(posedge clk_sys_in) begin
    if (sample_in) begin
      held_ff <= levels_in[chan_sel_in * 8 +: 8];
    end
  end
  // high when the held level is at or above the trial code
  assign cmp_hi_out = held_ff >= dac_code_in;
endmodule // sadc_analog_model

//--- sadc_ctrl_test.sv
// Purpose: self-checking bench for the converter control
// Assumes: rc period shortened to four clocks
// Notes:   exact codes only with the slow clock codes
`timescale 1ns/10ps
module sadc_ctrl_test;
  localparam int RC = 4;
  localparam logic [63:0] LV = 64'hf0c3a55a3c817e19;
  localparam logic [7:0] CTRL = sadc_pkg::SADC_CTRL_ADDR;
  localparam logic [7:0] STAT = sadc_pkg::SADC_IRQ_STAT;
  localparam logic [7:0] CLR = sadc_pkg::SADC_IRQ_CLR;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       sleep = 1'b0;
  logic       cmp;
  logic [7:0] rdata, dac, rv;
  logic [2:0] chan, pcfg;
  logic       chv, chv5, smp, xref, pwr, irq;
  int         errors = 0;
  int         total_checks = 0;
  int         cyc = 0;
  sadc_ctrl #(.CHANNELS(8), .RC_CYCLES(RC)) dut_u (
    .clk_sys_in(clk), .reset_n_in(rst_n), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .sleep_in(sleep), .cmp_hi_in(cmp), .rdata_out(rdata), .chan_sel_out(chan),
    .chan_valid_out(chv), .sample_out(smp), .dac_code_out(dac), .ext_ref_out(xref),
    .port_cfg_out(pcfg), .powered_out(pwr), .irq_out(irq));
  sadc_analog_model mdl_u (.clk_sys_in(clk), .levels_in(LV), .chan_sel_in(chan),
    .sample_in(smp), .dac_code_in(dac), .cmp_hi_out(cmp));
  // five-input variant on the same bus, watched for channel validity
  sadc_ctrl #(.CHANNELS(5), .RC_CYCLES(RC)) dut_small_u (
    .clk_sys_in(clk), .reset_n_in(rst_n), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .sleep_in(sleep), .cmp_hi_in(cmp), .rdata_out(), .chan_sel_out(),
    .chan_valid_out(chv5), .sample_out(), .dac_code_out(), .ext_ref_out(),
    .port_cfg_out(), .powered_out(), .irq_out());
  always #20 clk = ~clk;
  // cycle count and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  // power on, start, poll until the start bit drops
  task automatic convert(input logic [1:0] cs, input logic [2:0] ch, output int took);
    int t0;
    wr_reg(CTRL, {cs, ch, 3'h1});
    rd_reg(CTRL);
    chk("control readback", {cs, ch, 3'h1}, rv);
    chk("powered", 8'h01, {7'h0, pwr});
    wr_reg(CTRL, {cs, ch, 3'h5});
    t0 = cyc;
    rv = 8'h04;
    while (rv[2] === 1'b1 && cyc - t0 < 2000) rd_reg(CTRL);
    took = cyc - t0;
    chk("start bit cleared", 8'h00, {7'h0, rv[2]});
  endtask
  task automatic t_reset;
    rd_reg(CTRL);
    chk("control reset", 8'h00, rv);
    wr_reg(CTRL, 8'h02);
    rd_reg(CTRL);
    chk("reserved bit", 8'h00, rv);
    rd_reg(8'h55);
    chk("unmapped read", 8'h00, rv);
  endtask
  task automatic t_ports;
    for (int p = 0; p < 8; p++) begin
      wr_reg(sadc_pkg::SADC_PCFG_ADDR, 8'(p) | 8'hf8);
      rd_reg(sadc_pkg::SADC_PCFG_ADDR);
      chk("port cfg", 8'(p), rv);
      chk("ext ref", 8'(p == 1 || p == 3 || p == 5), {7'h0, xref});
    end
  endtask
  // every clock code: duration, done flag, interrupt and clear
  task automatic t_clocks;
    int per [4];
    int took;
    per = '{2, 8, 32, RC};
    wr_reg(sadc_pkg::SADC_IRQ_EN, 8'h01);
    for (int k = 0; k < 4; k++) begin
      convert(2'(k), 3'h1, took);
      // nine periods plus start, done and polling latency of about five cycles
      chk("duration", 8'h01, 8'(took - 9 * per[k] inside {[4:6]}));
      rd_reg(STAT);
      chk("done flag", 8'h01, {7'h0, rv[0]});
      chk("irq raised", 8'h01, {7'h0, irq});
      wr_reg(CLR, 8'h01);
      rd_reg(STAT);
      chk("done flag cleared", 8'h00, {7'h0, rv[0]});
      chk("irq cleared", 8'h00, {7'h0, irq});
    end
  endtask
  task automatic t_chan;
    int took;
    wr_reg(sadc_pkg::SADC_IRQ_EN, 8'h00);
    for (int c = 0; c < 8; c++) begin
      convert(sadc_pkg::SADC_CS_DIV8, 3'(c), took);
      chk("channel", 8'(c), {5'h0, chan});
      chk("channel valid", 8'h01, {7'h0, chv});
      chk("small variant valid", 8'(c < 5), {7'h0, chv5});
      rd_reg(sadc_pkg::SADC_RESULT_ADDR);
      chk("result", LV[c * 8 +: 8], rv);
    end
    chk("irq masked", 8'h00, {7'h0, irq});
  endtask
  // abort mid-conversion, then a non-rc start in sleep
  task automatic t_abort;
    int took;
    wr_reg(CLR, 8'h01);
    wr_reg(CTRL, 8'h91);
    wr_reg(CTRL, 8'h95);
    repeat (40) @(posedge clk);
    wr_reg(CTRL, 8'h91);
    repeat (400) @(posedge clk);
    rd_reg(sadc_pkg::SADC_RESULT_ADDR);
    chk("result kept", LV[63:56], rv);
    // sleep arriving during a non-rc conversion aborts it
    wr_reg(CTRL, 8'h95);
    repeat (40) @(posedge clk);
    sleep <= 1'b1;
    repeat (400) @(posedge clk);
    rd_reg(sadc_pkg::SADC_RESULT_ADDR);
    chk("result kept in sleep", LV[63:56], rv);
    rd_reg(sadc_pkg::SADC_SLEEP_ADDR);
    chk("sleep status", 8'h01, rv);
    wr_reg(CTRL, 8'h95);
    repeat (400) @(posedge clk);
    rd_reg(STAT);
    chk("no done flag", 8'h00, {7'h0, rv[0]});
    convert(sadc_pkg::SADC_CS_RC, 3'h3, took);
    rd_reg(STAT);
    chk("rc runs in sleep", 8'h01, {7'h0, rv[0]});
    @(posedge clk);
    sleep <= 1'b0;
  endtask
  // reset in mid-conversion clears control, status and the powered output
  task automatic t_rerst;
    wr_reg(CTRL, 8'hfd);
    repeat (8) @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(CTRL);
    chk("control after reset", 8'h00, rv);
    rd_reg(STAT);
    chk("status after reset", 8'h00, rv);
    chk("powered after reset", 8'h00, {7'h0, pwr});
  endtask
  task automatic finish_test;
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_ports();
    t_clocks();
    t_chan();
    t_abort();
    t_rerst();
    finish_test();
  end
endmodule // sadc_ctrl_test
